/* hw/bdp_target.sv */
// target end: debug command decoder and executor
// What this block does
// - all codes and data move MSB first
// - halted commands only while halted, others always
// - host starts each command with code byte
// - host waits 16 to 511 cycles per delay
// - 512 idle cycles abort the current command
// - only low 14 address bits are used
// - sync request answers with a timed pulse
// - code 18 resets the MCU, any mode
// - code 90 halts only when permit set
// - E4 reads, C4 writes status/control register
// - E0 returns one memory byte after delay
// - E1 returns status then memory byte
// - C0 writes memory byte during the delay
// - C1 writes byte, then returns status
// - E2 reads, C2 loads breakpoint register
// - 08 leaves halt and resumes at PC
// - 10 steps one instruction then halts
// - 80 streams bytes from incrementing addresses
// - 88 stores bytes at incrementing addresses
// - 6B reads, 4B writes flags and PC
// - permit clear refuses halt, keeps others
// - host checks status bit 6 (active), seen as rd[5] before the last bit, after halt
`timescale 1ns/1ns
`include "bdp_cfg.svh"
module bdp_target #(
	parameter logic [7:0] SYNC_LEN = 8'(`BDP_SYNC_LEN)
) (
	// clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// debug link
	bdp_link_if.target            link,
	// memory access
	output logic                  mem_req,
	output logic                  mem_we,
	output logic [13:0]           mem_addr,
	output logic [7:0]            mem_wdata,
	input  wire logic [7:0]       mem_rdata,
	// cpu control and registers
	output logic                  mcu_reset_req,
	output logic                  cpu_resume,
	output logic                  cpu_step,
	input  wire logic             cpu_step_done,
	input  wire logic [15:0]      cpu_flags_pc,
	input  wire logic [13:0]      cpu_spc,
	output logic                  cpu_reg_wr,
	output logic                  cpu_reg_sel,
	output logic [15:0]           cpu_reg_wdata,
	// debug state towards the cpu
	output logic                  debug_mode_active_flag,
	output logic [15:0]           breakpoint_match_reg,
	output logic [1:0]            bkpt_ctrl
);
	import bdp_pkg::*;

	typedef struct packed {
		bdp_tst_t   st;
		logic [7:0] cmd;
		bdp_shape_t shp;
		logic [4:0] cnt;
		logic [23:0] rx;
		logic [15:0] tx;
		logic [13:0] addr;
		logic [7:0] scr;
		logic [15:0] bkpt;
		logic       stepping;
		logic [7:0] sync_cnt;
		logic       t_valid;
		logic       t_bit;
		logic       t_sync;
		logic       mem_req;
		logic       mem_we;
		logic [13:0] mem_addr;
		logic [7:0] mem_wdata;
		logic       mcu_rst;
		logic       resume;
		logic       step;
		logic       reg_wr;
		logic       reg_sel;
		logic [15:0] reg_wdata;
	} bdp_tgt_s_t;

	bdp_tgt_s_t s_r;
	bdp_tgt_s_t s_nxt;
	logic       soft_rst;
	logic [7:0] code_in;
	logic [13:0] a;
	bdp_shape_t shp_in;

	// ==========================================================
	// soft reset watchdog
	bdp_idle_timer #(
		.LIMIT(10'(`BDP_SOFT_RST))
	) u_idle (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.activity (link.h_strobe),
		.soft_rst (soft_rst)
	);

	// ==========================================================
	// command decode and execution
	always_comb
	begin
		s_nxt = s_r;
		code_in = {s_r.rx[6:0], link.h_bit};
		shp_in = bdp_cmd_shape(code_in);
		// address from the field, else the running block address
		if (s_r.shp.out_bits == 5'd24)
			a = s_r.rx[21:8];
		else if (s_r.shp.out_bits == 5'd16)
			a = s_r.rx[13:0];
		else
			a = s_r.addr;
		s_nxt.t_valid = 1'b0;
		s_nxt.mem_req = 1'b0;
		s_nxt.mcu_rst = 1'b0;
		s_nxt.resume = 1'b0;
		s_nxt.step = 1'b0;
		s_nxt.reg_wr = 1'b0;
		// reference pulse for speed sync
		if (s_r.sync_cnt != 8'h00)
			s_nxt.sync_cnt = s_r.sync_cnt - 8'h01;
		if (cpu_step_done && s_r.stepping)
		begin
			s_nxt.stepping = 1'b0;
			s_nxt.scr[`BDP_SCR_ACTIVE] = 1'b1;
		end
		if (link.h_sync)
		begin
			s_nxt.sync_cnt = SYNC_LEN;
			s_nxt.st = TS_CMD;
			s_nxt.cnt = 5'd0;
		end
		else if (soft_rst)
		begin
			s_nxt.st = TS_CMD;
			s_nxt.cnt = 5'd0;
		end
		else
		begin
			unique case (s_r.st)
				TS_CMD:
					if (link.h_strobe)
					begin
						s_nxt.rx = {s_r.rx[22:0], link.h_bit};
						s_nxt.cnt = s_r.cnt + 5'd1;
						if (s_r.cnt == 5'd7)
						begin
							s_nxt.cmd = code_in;
							s_nxt.shp = shp_in;
							s_nxt.cnt = 5'd0;
							if (!shp_in.known || (shp_in.halted_only &&
								!s_r.scr[`BDP_SCR_ACTIVE]))
								s_nxt.st = TS_DISCARD;
							else if (shp_in.out_bits != 5'd0)
								s_nxt.st = TS_RECV;
							else
								s_nxt.st = TS_EXEC;
						end
					end
				TS_RECV:
					if (link.h_strobe)
					begin
						s_nxt.rx = {s_r.rx[22:0], link.h_bit};
						s_nxt.cnt = s_r.cnt + 5'd1;
						if (s_r.cnt + 5'd1 == s_r.shp.out_bits)
							s_nxt.st = TS_EXEC;
					end
				TS_EXEC:
				begin
					s_nxt.addr = a;
					s_nxt.cnt = 5'd0;
					s_nxt.st = (s_r.shp.in_bits != 5'd0) ? TS_SEND : TS_CMD;
					unique case (s_r.cmd)
						`BDP_CMD_RESET:
							s_nxt.mcu_rst = 1'b1;
						`BDP_CMD_HALT:
							if (s_r.scr[`BDP_SCR_PERMIT])
								s_nxt.scr[`BDP_SCR_ACTIVE] = 1'b1;
						`BDP_CMD_STAT_RD:
							s_nxt.tx = {s_r.scr, 8'h00};
						`BDP_CMD_CTRL_WR:
							s_nxt.scr = (s_r.rx[7:0] & `BDP_SCR_WMASK) |
								(s_r.scr & ~`BDP_SCR_WMASK);
						`BDP_CMD_MEM_RD, `BDP_CMD_MEM_RD_ST, `BDP_CMD_BLK_RD:
						begin
							s_nxt.mem_req = 1'b1;
							s_nxt.mem_we = 1'b0;
							s_nxt.mem_addr = a;
							s_nxt.st = TS_FETCH;
						end
						`BDP_CMD_MEM_WR, `BDP_CMD_MEM_WR_ST, `BDP_CMD_BLK_WR:
						begin
							s_nxt.mem_req = 1'b1;
							s_nxt.mem_we = 1'b1;
							s_nxt.mem_addr = a;
							s_nxt.mem_wdata = s_r.rx[7:0];
							s_nxt.tx = {s_r.scr, 8'h00};
						end
						`BDP_CMD_BKPT_RD:
							s_nxt.tx = s_r.bkpt;
						`BDP_CMD_BKPT_WR:
							s_nxt.bkpt = {2'b00, s_r.rx[13:0]};
						`BDP_CMD_GO:
						begin
							s_nxt.scr[`BDP_SCR_ACTIVE] = 1'b0;
							s_nxt.resume = 1'b1;
						end
						`BDP_CMD_STEP:
						begin
							s_nxt.scr[`BDP_SCR_ACTIVE] = 1'b0;
							s_nxt.stepping = 1'b1;
							s_nxt.step = 1'b1;
						end
						`BDP_CMD_FPC_RD:
							s_nxt.tx = cpu_flags_pc;
						`BDP_CMD_SPC_RD:
							s_nxt.tx = {2'b00, cpu_spc};
						`BDP_CMD_FPC_WR, `BDP_CMD_SPC_WR:
						begin
							s_nxt.reg_wr = 1'b1;
							s_nxt.reg_sel = (s_r.cmd == `BDP_CMD_SPC_WR);
							s_nxt.reg_wdata = (s_r.cmd == `BDP_CMD_SPC_WR) ?
								{2'b00, s_r.rx[13:0]} : s_r.rx[15:0];
						end
						default: ;
					endcase
					// block write: next byte goes to the next address
					if (s_r.cmd == `BDP_CMD_BLK_WR)
					begin
						s_nxt.addr = a + 14'h0001;
						s_nxt.shp.out_bits = 5'd8;
						s_nxt.st = TS_RECV;
					end
				end
				TS_FETCH:
				begin
					// read data is valid one cycle after the request
					if (s_r.cmd == `BDP_CMD_MEM_RD_ST)
						s_nxt.tx = {s_r.scr, mem_rdata};
					else
						s_nxt.tx = {mem_rdata, 8'h00};
					s_nxt.st = TS_SEND;
				end
				TS_SEND:
					if (link.h_strobe)
					begin
						s_nxt.t_valid = 1'b1;
						s_nxt.t_bit = s_r.tx[15];
						s_nxt.tx = {s_r.tx[14:0], 1'b0};
						s_nxt.cnt = s_r.cnt + 5'd1;
						if (s_r.cnt + 5'd1 == s_r.shp.in_bits)
						begin
							s_nxt.cnt = 5'd0;
							s_nxt.st = TS_CMD;
							if (s_r.cmd == `BDP_CMD_BLK_RD)
							begin
								s_nxt.addr = s_r.addr + 14'h0001;
								s_nxt.shp.out_bits = 5'd0;
								s_nxt.st = TS_EXEC;
							end
						end
					end
				TS_DISCARD: ; // wait for soft reset or sync
			endcase
		end
		s_nxt.t_sync = (s_nxt.sync_cnt != 8'h00);
	end

	// ==========================================================
	// state register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_r <= '0;
			s_r.st <= TS_CMD;
			s_r.scr <= `BDP_SCR_RST;
			s_r.bkpt <= `BDP_BKPT_RST;
		end
		else
			s_r <= s_nxt;
	end

	// outputs straight from the state
	assign link.t_valid = s_r.t_valid;
	assign link.t_bit = s_r.t_bit;
	assign link.t_sync = s_r.t_sync;
	assign mem_req = s_r.mem_req;
	assign mem_we = s_r.mem_we;
	assign mem_addr = s_r.mem_addr;
	assign mem_wdata = s_r.mem_wdata;
	assign mcu_reset_req = s_r.mcu_rst;
	assign cpu_resume = s_r.resume;
	assign cpu_step = s_r.step;
	assign cpu_reg_wr = s_r.reg_wr;
	assign cpu_reg_sel = s_r.reg_sel;
	assign cpu_reg_wdata = s_r.reg_wdata;
	assign debug_mode_active_flag = s_r.scr[`BDP_SCR_ACTIVE];
	assign breakpoint_match_reg = s_r.bkpt;
	assign bkpt_ctrl = s_r.scr[5:4];
endmodule

/* pkg/bdp_cfg.svh */
// constants of the background debug command port
`ifndef BDP_CFG_SVH
`define BDP_CFG_SVH
// command codes
`define BDP_CMD_RESET 8'h18
`define BDP_CMD_HALT 8'h90
`define BDP_CMD_STAT_RD 8'hE4
`define BDP_CMD_CTRL_WR 8'hC4
`define BDP_CMD_MEM_RD 8'hE0
`define BDP_CMD_MEM_RD_ST 8'hE1
`define BDP_CMD_MEM_WR 8'hC0
`define BDP_CMD_MEM_WR_ST 8'hC1
`define BDP_CMD_BKPT_RD 8'hE2
`define BDP_CMD_BKPT_WR 8'hC2
`define BDP_CMD_GO 8'h08
`define BDP_CMD_STEP 8'h10
`define BDP_CMD_BLK_RD 8'h80
`define BDP_CMD_BLK_WR 8'h88
`define BDP_CMD_FPC_RD 8'h6B
`define BDP_CMD_FPC_WR 8'h4B
`define BDP_CMD_SPC_RD 8'h6F
`define BDP_CMD_SPC_WR 8'h4F
// status/control fields
`define BDP_SCR_PERMIT 7
`define BDP_SCR_ACTIVE 6
`define BDP_SCR_WMASK 8'hB0
`define BDP_SCR_RST 8'h00
`define BDP_BKPT_RST 16'h0000
// timing in debug clock cycles
`define BDP_DLY_MIN 16
`define BDP_DLY_MAX 511
`define BDP_SOFT_RST 512
`define BDP_SYNC_LEN 128
// host register offsets and fields
`define BDP_REG_CTRL 5'h00
`define BDP_REG_ADDR 5'h04
`define BDP_REG_WDATA 5'h08
`define BDP_REG_RDATA 5'h0C
`define BDP_REG_STAT 5'h10
`define BDP_CTRL_GO 8
`define BDP_CTRL_CONT 9
`define BDP_CTRL_SYNC 10
`endif

/* pkg/bdp_pkg.sv */
// types and command shape decoding of the debug command port
`include "bdp_cfg.svh"
package bdp_pkg;
	typedef struct packed {
		logic       known;
		logic       halted_only;
		logic [4:0] out_bits;
		logic       dly;
		logic [4:0] in_bits;
	} bdp_shape_t;

	typedef enum logic [2:0] {TS_CMD, TS_RECV, TS_EXEC, TS_FETCH, TS_SEND, TS_DISCARD} bdp_tst_t;
	typedef enum logic [2:0] {HS_IDLE, HS_SRST, HS_SYNC, HS_OUT, HS_DLY, HS_IN, HS_INW} bdp_hst_t;

	// field layout of a command after its code byte
	function automatic bdp_shape_t bdp_cmd_shape(input logic [7:0] code);
		bdp_shape_t s;
		s = '0;
		unique case (code)
			`BDP_CMD_RESET:     s = '{1'b1, 1'b0, 5'd0, 1'b0, 5'd0};
			`BDP_CMD_HALT:      s = '{1'b1, 1'b0, 5'd0, 1'b1, 5'd0};
			`BDP_CMD_STAT_RD:   s = '{1'b1, 1'b0, 5'd0, 1'b0, 5'd8};
			`BDP_CMD_CTRL_WR:   s = '{1'b1, 1'b0, 5'd8, 1'b0, 5'd0};
			`BDP_CMD_MEM_RD:    s = '{1'b1, 1'b0, 5'd16, 1'b1, 5'd8};
			`BDP_CMD_MEM_RD_ST: s = '{1'b1, 1'b0, 5'd16, 1'b1, 5'd16};
			`BDP_CMD_MEM_WR:    s = '{1'b1, 1'b0, 5'd24, 1'b1, 5'd0};
			`BDP_CMD_MEM_WR_ST: s = '{1'b1, 1'b0, 5'd24, 1'b1, 5'd8};
			`BDP_CMD_BKPT_RD:   s = '{1'b1, 1'b0, 5'd0, 1'b0, 5'd16};
			`BDP_CMD_BKPT_WR:   s = '{1'b1, 1'b0, 5'd16, 1'b0, 5'd0};
			`BDP_CMD_GO:        s = '{1'b1, 1'b1, 5'd0, 1'b1, 5'd0};
			`BDP_CMD_STEP:      s = '{1'b1, 1'b1, 5'd0, 1'b1, 5'd0};
			`BDP_CMD_BLK_RD:    s = '{1'b1, 1'b1, 5'd16, 1'b1, 5'd8};
			`BDP_CMD_BLK_WR:    s = '{1'b1, 1'b1, 5'd24, 1'b1, 5'd0};
			`BDP_CMD_FPC_RD:    s = '{1'b1, 1'b1, 5'd0, 1'b1, 5'd16};
			`BDP_CMD_FPC_WR:    s = '{1'b1, 1'b1, 5'd16, 1'b1, 5'd0};
			`BDP_CMD_SPC_RD:    s = '{1'b1, 1'b1, 5'd0, 1'b1, 5'd16};
			`BDP_CMD_SPC_WR:    s = '{1'b1, 1'b1, 5'd16, 1'b1, 5'd0};
			default:            s = '0;
		endcase
		return s;
	endfunction
endpackage

/* pkg/bdp_link_if.sv */
// serial debug link between host pod and target
`timescale 1ns/1ns
interface bdp_link_if;
	logic h_strobe;
	logic h_bit;
	logic h_sync;
	logic t_valid;
	logic t_bit;
	logic t_sync;
	modport host (output h_strobe, output h_bit, output h_sync,
		input t_valid, input t_bit, input t_sync);
	modport target (input h_strobe, input h_bit, input h_sync,
		output t_valid, output t_bit, output t_sync);
endinterface

/* hw/bdp_idle_timer.sv */
// idle watchdog of the debug link, flags a soft reset
`timescale 1ns/1ns
`include "bdp_cfg.svh"
module bdp_idle_timer #(
	parameter logic [9:0] LIMIT = 10'(`BDP_SOFT_RST)
) (
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// link activity and result
	input  wire logic activity,
	output logic      soft_rst
);
	typedef struct packed {
		logic [9:0] cnt;
		logic       fire;
	} bdp_tmr_s_t;
	bdp_tmr_s_t s_r;
	bdp_tmr_s_t s_nxt;

	// count idle cycles, fire once on reaching the limit
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.fire = 1'b0;
		if (activity)
			s_nxt.cnt = 10'h000;
		else if (s_r.cnt != LIMIT)
		begin
			s_nxt.cnt = s_r.cnt + 10'h001;
			s_nxt.fire = (s_r.cnt == LIMIT - 10'h001);
		end
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s_r <= '{10'(`BDP_SOFT_RST), 1'b0};
		else
			s_r <= s_nxt;
	end

	assign soft_rst = s_r.fire;
endmodule

/* hw/bdp_host.sv */
// host end: AHB-Lite controlled debug pod
`timescale 1ns/1ns
`include "bdp_cfg.svh"
module bdp_host #(
	parameter logic [9:0] DLY = 10'(`BDP_DLY_MIN),
	parameter logic [9:0] SRST = 10'(`BDP_SOFT_RST + 2)
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// debug link
	bdp_link_if.host         link
);
	import bdp_pkg::*;

	typedef struct packed {
		bdp_hst_t   st;
		logic [7:0] code;
		bdp_shape_t shp;
		logic [39:0] out;
		logic [5:0] total;
		logic [5:0] cnt;
		logic [9:0] dcnt;
		logic [15:0] rd;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic       blk_open;
		logic       chk;
		logic       seen;
		logic [15:0] sync_len;
		logic       wr_pend;
		logic [4:0] wr_addr;
		logic [31:0] hrdata;
		logic       strobe;
		logic       bitv;
		logic       sync;
	} bdp_hst_s_t;

	bdp_hst_s_t s_r;
	bdp_hst_s_t s_nxt;
	logic       busy;
	logic [23:0] pay;

	// ==========================================================
	// register bus, link sequencer
	always_comb
	begin
		s_nxt = s_r;
		busy = (s_r.st != HS_IDLE);
		s_nxt.strobe = 1'b0;
		s_nxt.sync = 1'b0;
		s_nxt.shp = bdp_cmd_shape(s_r.code);
		// payload after the code byte, left aligned
		if (s_nxt.shp.out_bits == 5'd24)
			pay = {s_r.addr, s_r.wdata[7:0]};
		else if (s_nxt.shp.out_bits == 5'd16)
			pay = {(s_nxt.shp.in_bits != 5'd0) ? s_r.addr : s_r.wdata, 8'h00};
		else
			pay = {s_r.wdata[7:0], 16'h0000};
		// address phase: latch read data, remember writes
		s_nxt.wr_pend = 1'b0;
		if (hsel && htrans[1] && hready)
		begin
			s_nxt.wr_pend = hwrite;
			s_nxt.wr_addr = haddr[4:0];
			unique case (haddr[4:0])
				`BDP_REG_CTRL:  s_nxt.hrdata = {24'h000000, s_r.code};
				`BDP_REG_ADDR:  s_nxt.hrdata = {16'h0000, s_r.addr};
				`BDP_REG_WDATA: s_nxt.hrdata = {16'h0000, s_r.wdata};
				`BDP_REG_RDATA: s_nxt.hrdata = {16'h0000, s_r.rd};
				`BDP_REG_STAT:  s_nxt.hrdata = {s_r.sync_len, 13'h0000,
					s_r.chk, s_r.blk_open, busy};
				default:        s_nxt.hrdata = 32'h00000000;
			endcase
		end
		// data phase write, ignored while busy
		if (s_r.wr_pend && !busy)
			unique case (s_r.wr_addr)
				`BDP_REG_ADDR:  s_nxt.addr = hwdata[15:0];
				`BDP_REG_WDATA: s_nxt.wdata = hwdata[15:0];
				`BDP_REG_CTRL:
					if (hwdata[`BDP_CTRL_SYNC])
					begin
						s_nxt.sync = 1'b1;
						s_nxt.sync_len = 16'h0000;
						s_nxt.seen = 1'b0;
						s_nxt.blk_open = 1'b0;
						s_nxt.st = HS_SYNC;
					end
					else if (hwdata[`BDP_CTRL_CONT] && s_r.blk_open)
						s_nxt.st = HS_SRST; // marks a continuation below
					else if (hwdata[`BDP_CTRL_GO] &&
						(!s_r.chk || hwdata[7:0] == `BDP_CMD_STAT_RD))
					begin
						s_nxt.code = hwdata[7:0];
						s_nxt.dcnt = s_r.blk_open ? SRST : 10'h001;
						s_nxt.st = HS_SRST;
						s_nxt.blk_open = 1'b0;
					end
				default: ;
			endcase
		unique case (s_r.st)
			HS_IDLE: ;
			HS_SRST:
				if (s_r.blk_open)
				begin
					// next byte of an open block
					s_nxt.rd = 16'h0000;
					s_nxt.cnt = 6'd0;
					s_nxt.out = {s_r.wdata[7:0], 32'h00000000};
					s_nxt.total = 6'd8;
					s_nxt.dcnt = DLY;
					s_nxt.st = (s_r.code == `BDP_CMD_BLK_WR) ? HS_OUT : HS_DLY;
				end
				else if (s_r.dcnt > 10'h001)
					s_nxt.dcnt = s_r.dcnt - 10'h001;
				else
				begin
					s_nxt.rd = 16'h0000;
					s_nxt.cnt = 6'd0;
					s_nxt.out = {s_r.code, pay, 8'h00};
					s_nxt.total = 6'd8 + {1'b0, s_nxt.shp.out_bits};
					s_nxt.dcnt = DLY;
					s_nxt.st = HS_OUT;
					s_nxt.chk = (s_r.code == `BDP_CMD_HALT);
					s_nxt.blk_open = (s_r.code == `BDP_CMD_BLK_RD) ||
						(s_r.code == `BDP_CMD_BLK_WR);
				end
			HS_SYNC:
				if (link.t_sync)
				begin
					s_nxt.seen = 1'b1;
					s_nxt.sync_len = s_r.sync_len + 16'h0001;
				end
				else if (s_r.seen)
					s_nxt.st = HS_IDLE;
			HS_OUT:
			begin
				s_nxt.strobe = 1'b1;
				s_nxt.bitv = s_r.out[39];
				s_nxt.out = {s_r.out[38:0], 1'b0};
				s_nxt.cnt = s_r.cnt + 6'd1;
				if (s_r.cnt + 6'd1 == s_r.total)
				begin
					s_nxt.cnt = 6'd0;
					if (s_nxt.shp.dly)
						s_nxt.st = HS_DLY;
					else if (s_nxt.shp.in_bits != 5'd0)
					begin
						// one spare cycle so the target has decoded the code
						s_nxt.dcnt = 10'h001;
						s_nxt.st = HS_DLY;
					end
					else
						s_nxt.st = HS_IDLE;
				end
			end
			HS_DLY:
				if (s_r.dcnt > 10'h001)
					s_nxt.dcnt = s_r.dcnt - 10'h001;
				else
					s_nxt.st = (s_nxt.shp.in_bits != 5'd0) ? HS_IN : HS_IDLE;
			HS_IN:
			begin
				s_nxt.strobe = 1'b1;
				s_nxt.st = HS_INW;
			end
			HS_INW:
				if (link.t_valid)
				begin
					s_nxt.rd = {s_r.rd[14:0], link.t_bit};
					s_nxt.cnt = s_r.cnt + 6'd1;
					s_nxt.st = HS_IN;
					if (s_r.cnt + 6'd1 == {1'b0, s_nxt.shp.in_bits})
					begin
						s_nxt.st = HS_IDLE;
						if (s_r.code == `BDP_CMD_STAT_RD && s_r.rd[5])
							s_nxt.chk = 1'b0;
					end
				end
		endcase
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_r <= '0;
			s_r.st <= HS_IDLE;
		end
		else
			s_r <= s_nxt;
	end

	// outputs straight from the state, except hreadyout and hresp, which are tied to ready and okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_r.hrdata;
	assign link.h_strobe = s_r.strobe;
	assign link.h_bit = s_r.bitv;
	assign link.h_sync = s_r.sync;
endmodule

/* test/bdp_link_assertions.sv */
// checker of the serial debug link between host pod and target
`timescale 1ns/1ns
module bdp_link_assertions #(
	parameter int SYNC_LEN = 128
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// host to target
	input wire logic h_strobe,
	input wire logic h_bit,
	input wire logic h_sync,
	// target to host
	input wire logic t_valid,
	input wire logic t_bit,
	input wire logic t_sync
);
	logic [8:0] sync_cnt_r;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// length of the current reference pulse
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sync_cnt_r <= 9'h000;
		else if (t_sync)
			sync_cnt_r <= sync_cnt_r + 9'h001;
		else
			sync_cnt_r <= 9'h000;
	end

	// ==========================================
	// answer slots
	property p_answer_pulse; t_valid |=> !t_valid; endproperty
	a_answer_pulse: assert property (p_answer_pulse)
		else $error("answer bit held longer than one cycle");
	property p_answer_slot; t_valid |-> $past(h_strobe); endproperty
	a_answer_slot: assert property (p_answer_slot)
		else $error("answer bit without a read slot");
	property p_host_waits; t_valid |-> !h_strobe; endproperty
	a_host_waits: assert property (p_host_waits)
		else $error("host strobed while an answer was due");

	// ==========================================
	// speed reference pulse
	property p_sync_answer; h_sync |=> t_sync; endproperty
	a_sync_answer: assert property (p_sync_answer)
		else $error("no reference pulse after sync request");
	property p_sync_cause; $rose(t_sync) |-> $past(h_sync); endproperty
	a_sync_cause: assert property (p_sync_cause)
		else $error("reference pulse without request");
	property p_sync_len; $fell(t_sync) |-> sync_cnt_r == 9'(SYNC_LEN); endproperty
	a_sync_len: assert property (p_sync_len)
		else $error("reference pulse length wrong");
	property p_sync_quiet; t_sync |-> !h_strobe && !t_valid; endproperty
	a_sync_quiet: assert property (p_sync_quiet)
		else $error("bit traffic during reference pulse");
	property p_sync_req; h_sync |=> !h_sync; endproperty
	a_sync_req: assert property (p_sync_req)
		else $error("sync request longer than one cycle");
endmodule

/* test/bdp_test.sv */
// self-checking bench: host pod and target joined by the debug link
`timescale 1ns/1ns
`include "bdp_cfg.svh"
module bdp_test;
	import bdp_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, r, rd_v;
	logic [1:0]  htrans, bkpt_ctrl;
	logic [2:0]  hsize;
	logic        mem_req, mem_we, mcu_reset_req, cpu_resume, cpu_step, cpu_step_done;
	logic        cpu_reg_wr, cpu_reg_sel, act_flag;
	logic [13:0] mem_addr, cpu_spc;
	logic [7:0]  mem_wdata, mem_rdata, sh_in;
	logic [15:0] cpu_flags_pc, cpu_reg_wdata, bkpt, sh_out;
	logic [7:0]  mem [0:16383];
	int          n_rst, n_res, n_step, cyc, err_total, samples_checked;

	bdp_link_if lk();
	bdp_host u_bdp_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(lk));
	bdp_target u_bdp_target (.hclk(hclk), .hresetn(hresetn), .link(lk), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mcu_reset_req(mcu_reset_req), .cpu_resume(cpu_resume), .cpu_step(cpu_step),
		.cpu_step_done(cpu_step_done), .cpu_flags_pc(cpu_flags_pc), .cpu_spc(cpu_spc),
		.cpu_reg_wr(cpu_reg_wr), .cpu_reg_sel(cpu_reg_sel), .cpu_reg_wdata(cpu_reg_wdata),
		.debug_mode_active_flag(act_flag), .breakpoint_match_reg(bkpt), .bkpt_ctrl(bkpt_ctrl));
	bdp_link_assertions u_bdp_link_assertions (.hclk(hclk), .hresetn(hresetn),
		.h_strobe(lk.h_strobe), .h_bit(lk.h_bit), .h_sync(lk.h_sync),
		.t_valid(lk.t_valid), .t_bit(lk.t_bit), .t_sync(lk.t_sync));

	always #20 hclk = ~hclk;

	// memory reads asynchronously: the target samples the byte at the edge after its request
	assign mem_rdata = mem[mem_addr];

	// memory, cpu registers, pulse counters and wire shifters
	always @(posedge hclk)
	begin
		cpu_step_done <= cpu_step;
		if (mem_req && mem_we)
			mem[mem_addr] <= mem_wdata;
		if (cpu_reg_wr && !cpu_reg_sel)
			cpu_flags_pc <= cpu_reg_wdata;
		if (cpu_reg_wr && cpu_reg_sel)
			cpu_spc <= cpu_reg_wdata[13:0];
		n_rst += int'(mcu_reset_req);
		n_res += int'(cpu_resume);
		n_step += int'(cpu_step);
		if (lk.h_strobe)
			sh_out <= {sh_out[14:0], lk.h_bit};
		if (lk.t_valid)
			sh_in <= {sh_in[6:0], lk.t_bit};
		cyc++;
		if (cyc == 30000)
		begin
			err_total++;
			complete_run();
		end
	end

	task automatic complete_run();
		if (err_total == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one single AHB-Lite word transfer
	task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {27'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	// issue one link command and wait until the pod is idle
	task automatic cmd(input logic [2:0] f, input logic [7:0] c, input logic [15:0] a,
		input logic [15:0] d);
		int i;
		i = 0;
		xfer(1'b1, `BDP_REG_ADDR, {16'h0000, a});
		xfer(1'b1, `BDP_REG_WDATA, {16'h0000, d});
		xfer(1'b1, `BDP_REG_CTRL, {21'h0, f, c});
		do
		begin
			xfer(1'b0, `BDP_REG_STAT, 32'h0);
			i++;
		end
		while (r[0] !== 1'b1 && i < 4);
		while (r[0] !== 1'b0)
			xfer(1'b0, `BDP_REG_STAT, 32'h0);
		xfer(1'b0, `BDP_REG_RDATA, 32'h0);
		rd_v = r;
	endtask

	// main sequence
	initial
	begin
		{hclk, hresetn, hsel, hwrite, cpu_step_done} = 5'h00;
		{haddr, hwdata, htrans, hsize} = '0;
		{cpu_flags_pc, cpu_spc} = '0;
		{n_rst, n_res, n_step, cyc, err_total, samples_checked} = '0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		cmd(3'h1, 8'hE4, 16'h0, 16'h0);
		chk("status at reset", 32'h00, rd_v[7:0]);
		cmd(3'h1, 8'h90, 16'h0, 16'h0);
		cmd(3'h1, 8'hE4, 16'h0, 16'h0);
		chk("status halt refused", 32'h00, rd_v[7:0]);
		chk("active halt refused", 32'h0, act_flag);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		cmd(3'h1, 8'hC4, 16'h0, 16'h00FF);
		chk("control frame bits", 32'hC4FF, sh_out);
		cmd(3'h1, 8'hE4, 16'h0, 16'h0);
		chk("status after control", 32'hB0, rd_v[7:0]);
		chk("status answer bits", 32'hB0, sh_in);
		chk("breakpoint controls", 32'h3, bkpt_ctrl);
		cmd(3'h1, 8'h4B, 16'h0, 16'h8123);
		repeat (520) @(posedge hclk);
		chk("write while running", 32'h0, cpu_flags_pc);
		cmd(3'h1, 8'h90, 16'h0, 16'h0);
		cmd(3'h1, 8'hE4, 16'h0, 16'h0);
		chk("status after halt", 32'hF0, rd_v[7:0]);
		chk("active after halt", 32'h1, act_flag);
		cmd(3'h1, 8'hC0, 16'hC123, 16'h005A);
		chk("byte written", 32'h5A, mem[14'h0123]);
		cmd(3'h1, 8'hE0, 16'h0123, 16'h0);
		chk("byte read", 32'h5A, rd_v[7:0]);
		cmd(3'h1, 8'hE1, 16'h4123, 16'h0);
		chk("byte read with status", 32'hF05A, rd_v[15:0]);
		cmd(3'h1, 8'hC1, 16'h0200, 16'h00A5);
		chk("write status", 32'hF0, rd_v[7:0]);
		chk("byte written with status", 32'hA5, mem[14'h0200]);
		cmd(3'h1, 8'hC2, 16'h0, 16'hFFFF);
		chk("breakpoint output", 32'h3FFF, bkpt);
		cmd(3'h1, 8'hE2, 16'h0, 16'h0);
		chk("breakpoint read", 32'h3FFF, rd_v[15:0]);
		cmd(3'h1, 8'h4B, 16'h0, 16'h8123);
		chk("flags and counter written", 32'h8123, cpu_flags_pc);
		cmd(3'h1, 8'h6B, 16'h0, 16'h0);
		chk("flags and counter read", 32'h8123, rd_v[15:0]);
		cmd(3'h1, 8'h4F, 16'h0, 16'hFFFF);
		chk("shadow counter written", 32'h3FFF, cpu_spc);
		cmd(3'h1, 8'h6F, 16'h0, 16'h0);
		chk("shadow counter read", 32'h3FFF, rd_v[15:0]);
		for (int i = 0; i < 3; i++)
			cmd((i == 0) ? 3'h1 : 3'h2, 8'h88, 16'h0300, 16'(8'h11 * (i + 1)));
		for (int i = 0; i < 3; i++)
			chk("block written", 8'h11 * (i + 1), mem[14'h0300 + i]);
		for (int i = 0; i < 3; i++)
		begin
			cmd((i == 0) ? 3'h1 : 3'h2, 8'h80, 16'h0300, 16'h0);
			chk("block read", 8'h11 * (i + 1), rd_v[7:0]);
		end
		cmd(3'h1, 8'h10, 16'h0, 16'h0);
		chk("step pulses", 32'h1, n_step);
		cmd(3'h1, 8'hE4, 16'h0, 16'h0);
		chk("status after step", 32'hF0, rd_v[7:0]);
		cmd(3'h4, 8'h00, 16'h0, 16'h0);
		xfer(1'b0, `BDP_REG_STAT, 32'h0);
		chk("sync length", 32'h80, r[31:16]);
		cmd(3'h1, 8'h08, 16'h0, 16'h0);
		chk("resume pulses", 32'h1, n_res);
		chk("active after resume", 32'h0, act_flag);
		cmd(3'h1, 8'h18, 16'h0, 16'h0);
		chk("mcu reset pulses", 32'h1, n_rst);
		complete_run();
	end
endmodule
